// *** rtl/rtcam_mcd.sv ***
// missing oscillator detector: one-shot timeout on a stuck level
`timescale 1ns/1ps
module rtcam_mcd
    import rtcam_pkg::*;
#(
    parameter int unsigned TIMEOUT = MCD_TIMEOUT_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic osc_level,
    output logic      timeout_pulse
);
    localparam int unsigned CW = $clog2(TIMEOUT + 1);

    logic          prev_q;
    logic [CW-1:0] count_q;
    logic          fired_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= osc_level;
        end
    end

    // any edge restarts the window and re-arms the one-shot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q       <= '0;
            fired_q       <= 1'b0;
            timeout_pulse <= 1'b0;
        end else if (!enable || (osc_level != prev_q)) begin
            count_q       <= '0;
            fired_q       <= 1'b0;
            timeout_pulse <= 1'b0;
        end else if (count_q == CW'(TIMEOUT)) begin
            timeout_pulse <= !fired_q;
            fired_q       <= 1'b1;
        end else begin
            count_q       <= count_q + CW'(1);
            timeout_pulse <= 1'b0;
        end
    end
endmodule

// *** rtl/rtcam_pkg.sv ***
// shared constants for the rtc timer, alarm and clock monitor
package rtcam_pkg;
    // clock rate and timing figures
    localparam int unsigned MCLK_PERIOD_PS   = 25_000;
    localparam int unsigned MCD_TIMEOUT_US   = 100;
    localparam int unsigned XVALID_BLANK_MS  = 2;
    localparam int unsigned MCD_TIMEOUT_CYC  =
        (MCD_TIMEOUT_US * 1_000_000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int unsigned XVALID_BLANK_CYC =
        (XVALID_BLANK_MS * 1_000_000_000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

    // direct port offsets
    localparam logic ADR_INDIRECT_ADDR = 1'h0;
    localparam logic ADR_INDIRECT_DATA = 1'h1;

    // indirect register addresses
    localparam logic [3:0] IDX_HOLD0  = 4'h0;
    localparam logic [3:0] IDX_CTRL   = 4'h4;
    localparam logic [3:0] IDX_OSC    = 4'h5;
    localparam logic [3:0] IDX_ALARM0 = 4'h8;

    // control register fields
    localparam int unsigned CTL_RTC_EN  = 7;
    localparam int unsigned CTL_MCD_EN  = 6;
    localparam int unsigned CTL_FAIL    = 5;
    localparam int unsigned CTL_RUN     = 4;
    localparam int unsigned CTL_AEN     = 3;
    localparam int unsigned CTL_ALARM   = 2;
    localparam int unsigned CTL_SET     = 1;
    localparam int unsigned CTL_CAP     = 0;

    // oscillator control register fields
    localparam int unsigned OSC_XMODE   = 7;
    localparam int unsigned OSC_AGC     = 6;
    localparam int unsigned OSC_BIASX   = 5;
    localparam int unsigned OSC_XVALID  = 4;
    localparam int unsigned OSC_LFO     = 3;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
endpackage

// *** rtl/rtcam_sync.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module rtcam_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** rtl/rtcam_top.sv ***
// rtc timer with alarm, set/capture path and oscillator monitor
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module rtcam_top
    import rtcam_pkg::*;
#(
    parameter int unsigned BLANK_CYC   = XVALID_BLANK_CYC,
    parameter int unsigned MCD_CYC     = MCD_TIMEOUT_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rtc_osc,
    input  wire logic       crystal_amp_ok,
    output logic            alarm_event,
    output logic            oscillator_fail_flag,
    output logic            osc_power_enable,
    output logic            crystal_mode,
    output logic            auto_gain_control,
    output logic            bias_double_bit,
    output logic            low_freq_oscillator
);
    localparam int unsigned BW = $clog2(BLANK_CYC + 1);

    // true for indirect addresses that hold a byte of a 32-bit value
    function automatic logic is_value_byte(input logic [3:0] a);
        return (a[3:2] == IDX_HOLD0[3:2]) || (a[3:2] == IDX_ALARM0[3:2]);
    endfunction

    logic [3:0]  ind_addr_q;
    logic [7:0]  hold_q [4];
    logic [7:0]  alarm_q [4];
    logic [31:0] timer_q;
    logic        rtc_en_q;
    logic        mcd_en_q;
    logic        run_q;
    logic        aen_q;
    logic        autoreset_q;
    logic        set_q;
    logic        cap_q;
    logic        flag_q;
    logic        fail_q;
    logic        xmode_q;
    logic        agc_q;
    logic        biasx_q;
    logic        lfo_q;
    logic [BW-1:0] blank_q;
    logic        osc_prev_q;
    logic [7:0]  rdata_q;

    logic [1:0]  pin_s;
    logic        osc_s;
    logic        amp_s;
    logic        fail_pulse;
    logic        tick;
    logic        match;
    logic        data_wr;
    logic        data_rd;
    logic        ctl_wr;
    logic        xtal_valid;
    logic [31:0] hold_word;
    logic [31:0] alarm_word;
    logic [31:0] cmp_mask;
    logic [31:0] timer_inc;

    rtcam_sync #(
        .WIDTH (2)
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({crystal_amp_ok, rtc_osc}),
        .sync_out (pin_s)
    );

    assign osc_s = pin_s[0];
    assign amp_s = pin_s[1];

    rtcam_mcd #(
        .TIMEOUT (MCD_CYC)
    ) u_mcd (
        .mclk          (mclk),
        .rst           (rst),
        .enable        (mcd_en_q),
        .osc_level     (osc_s),
        .timeout_pulse (fail_pulse)
    );

    assign data_wr    = reg_wr && (reg_addr == ADR_INDIRECT_DATA);
    assign data_rd    = reg_rd && (reg_addr == ADR_INDIRECT_DATA);
    assign ctl_wr     = data_wr && (ind_addr_q == IDX_CTRL);
    assign hold_word  = {hold_q[3], hold_q[2], hold_q[1], hold_q[0]};
    assign alarm_word = {alarm_q[3], alarm_q[2], alarm_q[1], alarm_q[0]};

    // one timer step per rising oscillator edge, seen after the synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
        end
    end

    assign tick      = osc_s && !osc_prev_q && run_q;
    // low-frequency source steps bit 1, so bit 0 takes no part in the match
    assign timer_inc = lfo_q ? 32'h0000_0002 : 32'h0000_0001;
    assign cmp_mask  = lfo_q ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
    assign match     = (timer_q & cmp_mask) == (alarm_word & cmp_mask);

    // indirect address, advanced after each value-byte access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ind_addr_q <= 4'h0;
        end else if (reg_wr && (reg_addr == ADR_INDIRECT_ADDR)) begin
            ind_addr_q <= reg_wdata[3:0];
        end else if ((data_wr || data_rd) && is_value_byte(ind_addr_q)) begin
            ind_addr_q <= ind_addr_q + 4'h1;
        end
    end

    // holding bytes: software writes, capture overwrites with a snapshot
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                hold_q[i] <= RST_BYTE;
            end
        end else if (cap_q) begin
            for (int i = 0; i < 4; i++) begin
                hold_q[i] <= timer_q[8*i +: 8];
            end
        end else if (data_wr && (ind_addr_q[3:2] == IDX_HOLD0[3:2])) begin
            hold_q[ind_addr_q[1:0]] <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                alarm_q[i] <= RST_BYTE;
            end
        end else if (data_wr && (ind_addr_q[3:2] == IDX_ALARM0[3:2])) begin
            alarm_q[ind_addr_q[1:0]] <= reg_wdata;
        end
    end

    // control bits written by software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rtc_en_q    <= 1'b0;
            mcd_en_q    <= 1'b0;
            run_q       <= 1'b0;
            aen_q       <= 1'b0;
            autoreset_q <= 1'b0;
        end else if (ctl_wr) begin
            rtc_en_q    <= reg_wdata[CTL_RTC_EN];
            mcd_en_q    <= reg_wdata[CTL_MCD_EN];
            run_q       <= reg_wdata[CTL_RUN];
            aen_q       <= reg_wdata[CTL_AEN];
            autoreset_q <= reg_wdata[CTL_ALARM];
        end
    end

    // set and capture requests complete in the next cycle, then read back 0
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            set_q <= 1'b0;
            cap_q <= 1'b0;
        end else if (ctl_wr) begin
            set_q <= reg_wdata[CTL_SET];
            cap_q <= reg_wdata[CTL_CAP];
        end else begin
            set_q <= 1'b0;
            cap_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xmode_q <= 1'b0;
            agc_q   <= 1'b0;
            biasx_q <= 1'b0;
            lfo_q   <= 1'b0;
        end else if (data_wr && (ind_addr_q == IDX_OSC)) begin
            xmode_q <= reg_wdata[OSC_XMODE];
            agc_q   <= reg_wdata[OSC_AGC];
            biasx_q <= reg_wdata[OSC_BIASX];
            lfo_q   <= reg_wdata[OSC_LFO];
        end
    end

    // timer: the alarm tick holds the value, the tick after it clears it,
    // which is where the two extra cycles of each auto-reset period come from
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_q <= RST_WORD;
        end else if (set_q) begin
            timer_q <= hold_word;
        end else if (tick) begin
            if (flag_q && autoreset_q) begin
                timer_q <= RST_WORD;
            end else if (!flag_q && match && aen_q && autoreset_q) begin
                timer_q <= timer_q;
            end else begin
                timer_q <= timer_q + timer_inc;
            end
        end
    end

    // alarm flag: raised on a match tick, dropped on the next tick
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (ctl_wr && !reg_wdata[CTL_AEN]) begin
            flag_q <= 1'b0;
        end else if (tick) begin
            if (flag_q) begin
                flag_q <= 1'b0;
            end else begin
                flag_q <= match && aen_q;
            end
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fail_q <= 1'b0;
        end else if (fail_pulse) begin
            fail_q <= 1'b1;
        end else if (ctl_wr && !reg_wdata[CTL_FAIL]) begin
            fail_q <= 1'b0;
        end
    end

    // blanking window restarts whenever the crystal is powered down
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            blank_q <= '0;
        end else if (!(rtc_en_q && xmode_q)) begin
            blank_q <= '0;
        end else if (blank_q != BW'(BLANK_CYC)) begin
            blank_q <= blank_q + BW'(1);
        end
    end

    assign xtal_valid = amp_s && (blank_q == BW'(BLANK_CYC));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == ADR_INDIRECT_ADDR) begin
                rdata_q <= {4'h0, ind_addr_q};
            end else if (ind_addr_q[3:2] == IDX_HOLD0[3:2]) begin
                rdata_q <= hold_q[ind_addr_q[1:0]];
            end else if (ind_addr_q[3:2] == IDX_ALARM0[3:2]) begin
                rdata_q <= alarm_q[ind_addr_q[1:0]];
            end else if (ind_addr_q == IDX_CTRL) begin
                rdata_q <= {rtc_en_q, mcd_en_q, fail_q, run_q,
                            aen_q, flag_q, set_q, cap_q};
            end else if (ind_addr_q == IDX_OSC) begin
                rdata_q <= {xmode_q, agc_q, biasx_q, xtal_valid, lfo_q, 3'h0};
            end else begin
                rdata_q <= RST_BYTE;
            end
        end
    end

    // gain control is left to software: it is passed out as written
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alarm_event          <= 1'b0;
            oscillator_fail_flag <= 1'b0;
            osc_power_enable     <= 1'b0;
            crystal_mode         <= 1'b0;
            auto_gain_control    <= 1'b0;
            bias_double_bit      <= 1'b0;
            low_freq_oscillator  <= 1'b0;
        end else begin
            alarm_event          <= flag_q;
            oscillator_fail_flag <= fail_q;
            osc_power_enable     <= rtc_en_q;
            crystal_mode         <= xmode_q;
            auto_gain_control    <= agc_q;
            bias_double_bit      <= biasx_q;
            low_freq_oscillator  <= lfo_q;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// *** sim/rtcam_props.sv ***
// port checker for the rtc timer top
`timescale 1ns/1ps
module rtcam_props
    import rtcam_pkg::*;
#(
    parameter int unsigned MCD_CYC = MCD_TIMEOUT_CYC
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rtc_osc,
    input wire logic       crystal_amp_ok,
    input wire logic       alarm_event,
    input wire logic       oscillator_fail_flag,
    input wire logic       osc_power_enable,
    input wire logic       crystal_mode,
    input wire logic       auto_gain_control,
    input wire logic       bias_double_bit,
    input wire logic       low_freq_oscillator
);
    logic        osc_q;
    logic [3:0]  rise_q;
    logic [31:0] stuck_q;

    // raw pin history; the design sees it later through its synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_q   <= 1'b0;
            rise_q  <= 4'hf;
            stuck_q <= 32'h0000_0000;
        end else begin
            osc_q   <= rtc_osc;
            rise_q  <= (rtc_osc && !osc_q) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hf};
            stuck_q <= (rtc_osc != osc_q) ? 32'h0000_0000 : stuck_q + 32'h0000_0001;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    AST_ALARM_ONE_RTC: assert property (
        alarm_event && $rose(rtc_osc) |-> ##[1:6] !alarm_event)
        else $error("alarm event outlived one rtc cycle");
    AST_ALARM_ON_TICK: assert property (
        $rose(alarm_event) |-> rise_q <= 4'h8)
        else $error("alarm event without an rtc edge");
    AST_FAIL_AFTER_STUCK: assert property (
        $rose(oscillator_fail_flag) |-> stuck_q >= MCD_CYC)
        else $error("fail flag before timeout");
    AST_FAIL_CLEAR_BY_WRITE: assert property (
        $fell(oscillator_fail_flag) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("fail flag dropped on its own");
    AST_RDATA_HOLD: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_OSC_OUT_WRITE: assert property (
        $changed({crystal_mode, auto_gain_control, bias_double_bit, low_freq_oscillator})
        |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("oscillator setting changed without a write");
    AST_PWR_OUT_WRITE: assert property (
        $changed(osc_power_enable) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("power enable changed without a write");
    AST_ALARM_FALL: assert property (
        $fell(alarm_event) |-> rise_q <= 4'h8 || $past(reg_wr) || $past(reg_wr, 2))
        else $error("alarm event fell without cause");

    cover property ($rose(alarm_event));
    cover property ($rose(oscillator_fail_flag));
    cover property ($rose(crystal_mode));
endmodule

// *** sim/rtcam_top_tb.sv ***
// self-checking bench for the rtc timer top
`timescale 1ns/1ps
module rtcam_top_tb;
    import rtcam_pkg::*;
    localparam int unsigned MCD = 20;
    localparam int unsigned BLK = 50;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       reg_addr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       rtc_osc = 1'b0;
    logic       crystal_amp_ok = 1'b0;
    logic [7:0] reg_rdata;
    logic       alarm_event, oscillator_fail_flag, osc_power_enable, crystal_mode;
    logic       auto_gain_control, bias_double_bit, low_freq_oscillator;
    int         checks = 0;
    int         miscompares = 0;
    int         k;
    int         gap;
    logic [7:0] v;
    // osc write, readback, {crystal, gain, bias, lfo}
    logic [19:0] rows [6] = '{20'h8_0808, 20'h4_0404, 20'h2_0202, 20'h0_8081,
                              20'hF_FE8F, 20'h0_0000};
    // osc setting, alarm value, alarm period in rtc cycles
    logic [23:0] alm [2] = '{24'h00_0406, 24'h08_0504};

    rtcam_top #(.BLANK_CYC(BLK), .MCD_CYC(MCD)) rtcam_top_i (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rtc_osc(rtc_osc),
        .crystal_amp_ok(crystal_amp_ok), .alarm_event(alarm_event),
        .oscillator_fail_flag(oscillator_fail_flag), .osc_power_enable(osc_power_enable),
        .crystal_mode(crystal_mode), .auto_gain_control(auto_gain_control),
        .bias_double_bit(bias_double_bit), .low_freq_oscillator(low_freq_oscillator));

    always #12.5 mclk = ~mclk;

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one strobe cycle, then one idle cycle so a strobe is never driven twice at one edge
    task automatic wr(input logic a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask
    task automatic rd(input logic a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        step(1);
        reg_rd <= 1'b0;
        step(1);
        d = reg_rdata;
    endtask
    task automatic wi(input logic [3:0] idx, input logic [7:0] d);
        wr(ADR_INDIRECT_ADDR, {4'h0, idx});
        wr(ADR_INDIRECT_DATA, d);
    endtask
    task automatic ri(input logic [3:0] idx, output logic [7:0] d);
        wr(ADR_INDIRECT_ADDR, {4'h0, idx});
        rd(ADR_INDIRECT_DATA, d);
    endtask
    task automatic wr4(input logic [3:0] idx, input logic [31:0] w);
        wr(ADR_INDIRECT_ADDR, {4'h0, idx});
        for (int b = 0; b < 4; b++) wr(ADR_INDIRECT_DATA, w[8*b+:8]);
    endtask
    task automatic rd4(output logic [31:0] w);
        logic [7:0] b8;
        wr(ADR_INDIRECT_ADDR, {4'h0, IDX_HOLD0});
        for (int b = 0; b < 4; b++) begin
            rd(ADR_INDIRECT_DATA, b8);
            w[8*b+:8] = b8;
        end
    endtask
    // ten mclk per rtc cycle keeps the system clock above nine times the rtc rate
    task automatic tick(input int n);
        repeat (n) begin
            rtc_osc <= 1'b1;
            step(5);
            rtc_osc <= 1'b0;
            step(5);
        end
    endtask
    task automatic alarm_gap(output int g);
        int first;
        logic prev;
        first = -1;
        g = -1;
        prev = 1'b0;
        for (int n = 1; n <= 40; n++) begin
            tick(1);
            if (prev) chk(alarm_event, 1'b0);
            if (alarm_event && first >= 0 && g < 0) g = n - first;
            if (alarm_event && first < 0) first = n;
            prev = alarm_event;
        end
    endtask

    initial begin
        logic [31:0] w;
        step(8);
        rst <= 1'b0;
        step(1);
        ri(IDX_CTRL, v);
        chk(v, RST_BYTE);
        ri(IDX_OSC, v);
        chk(v, RST_BYTE);
        wi(4'hc, 8'h5a);
        ri(4'hc, v);
        chk(v, 8'h00);
        $display("reset and unmapped done");
        foreach (rows[i]) begin
            wi(IDX_OSC, rows[i][19:12]);
            ri(IDX_OSC, v);
            chk(v, rows[i][11:4]);
            chk({crystal_mode, auto_gain_control, bias_double_bit, low_freq_oscillator},
                rows[i][3:0]);
        end
        $display("oscillator settings done");
        wr4(IDX_HOLD0, 32'hffff_fffe);
        wr(ADR_INDIRECT_DATA, 8'h12); // auto-increment has reached control
        rd(ADR_INDIRECT_DATA, v);
        chk(v, 8'h10);
        tick(3);
        wr(ADR_INDIRECT_DATA, 8'h11);
        rd(ADR_INDIRECT_DATA, v);
        chk(v, 8'h10);
        rd4(w);
        chk(w, 32'h0000_0001);
        wr(ADR_INDIRECT_DATA, 8'h00);
        tick(2);
        wr(ADR_INDIRECT_DATA, 8'h01);
        rd4(w);
        chk(w, 32'h0000_0001);
        $display("set and capture done");
        foreach (alm[i]) begin
            wi(IDX_OSC, alm[i][23:16]);
            wr4(IDX_HOLD0, 32'h0000_0000);
            wr(ADR_INDIRECT_DATA, 8'h12);
            wr4(IDX_ALARM0, {24'h00_0000, alm[i][15:8]});
            wi(IDX_CTRL, 8'h1c);
            alarm_gap(gap);
            chk(gap, alm[i][7:0]);
        end
        k = 0;
        while (!alarm_event && k < 20) begin
            tick(1);
            k++;
        end
        chk(alarm_event, 1'b1);
        if (k >= 20) close_out();
        wi(IDX_CTRL, 8'h14);
        step(2);
        chk(alarm_event, 1'b0);
        rd(ADR_INDIRECT_DATA, v);
        chk(v, 8'h10);
        $display("alarm done");
        tick(2);
        wi(IDX_CTRL, 8'h40);
        chk(oscillator_fail_flag, 1'b0);
        k = 0;
        while (!oscillator_fail_flag && k < 60) begin
            step(1);
            k++;
        end
        chk(oscillator_fail_flag, 1'b1);
        if (k >= 60) close_out();
        rd(ADR_INDIRECT_DATA, v);
        chk(v, 8'h60);
        wr(ADR_INDIRECT_DATA, 8'h40);
        rd(ADR_INDIRECT_DATA, v);
        chk(v, 8'h40);
        $display("missing clock done");
        crystal_amp_ok <= 1'b1;
        wi(IDX_CTRL, 8'h80);
        wi(IDX_OSC, 8'h80);
        ri(IDX_OSC, v);
        chk(v, 8'h80);
        step(BLK + 10);
        ri(IDX_OSC, v);
        chk(v, 8'h90);
        chk(osc_power_enable, 1'b1);
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        step(1);
        chk({osc_power_enable, crystal_mode, oscillator_fail_flag}, 3'h0);
        ri(IDX_CTRL, v);
        chk(v, RST_BYTE);
        $display("crystal valid and reset done");
        close_out();
    end
endmodule

bind rtcam_top rtcam_props #(.MCD_CYC(MCD_CYC)) rtcam_props_i (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rtc_osc(rtc_osc),
    .crystal_amp_ok(crystal_amp_ok), .alarm_event(alarm_event),
    .oscillator_fail_flag(oscillator_fail_flag), .osc_power_enable(osc_power_enable),
    .crystal_mode(crystal_mode), .auto_gain_control(auto_gain_control),
    .bias_double_bit(bias_double_bit), .low_freq_oscillator(low_freq_oscillator));
